//--- logic/hbs_defs.svh
// Purpose: constants for the holding brake sequencer
// Assumes: 200 MHz control clock
// Notes:   times in their own units, cycle counts derived
`ifndef HBS_DEFS_SVH
`define HBS_DEFS_SVH
`define HBS_CLK_MHZ          200
`define HBS_TICK_MS          10
`define HBS_TICK_CYCLES      (`HBS_TICK_MS * 1000 * `HBS_CLK_MHZ)
`define HBS_DELAY_MAX        6'h32
`define HBS_DELAY_RST        6'h00
`define HBS_WAIT_RST         7'h32
`define HBS_SPEED_RST        14'h0064
`define HBS_SEL_RST          2'h1
`define HBS_SEL_OFF          2'h0
`endif

//--- logic/hbs_pkg.sv
// Purpose: types for the holding brake sequencer
// Assumes: nothing
// Notes:   state enumeration only
package hbs_pkg;
  typedef enum logic [2:0] {
    HBS_OFF,
    HBS_ON,
    HBS_STOP_DELAY,
    HBS_RUN_WAIT
  } hbs_state_t;
endpackage : hbs_pkg

//--- logic/hbs_tick_if.sv
// Purpose: carries the 10 ms tick between the divider and the sequencer
// Assumes: one clock
// Notes:   tick is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface hbs_tick_if;
  logic tick;
  logic clr;
  modport src (output tick, input clr);
  modport dst (input tick, output clr);
endinterface : hbs_tick_if
`default_nettype wire

//--- logic/hbs_tick_div.sv
// Purpose: divides the control clock down to a 10 ms enable pulse
// Assumes: clr restarts the period so the first tick is a full period away
// Notes:   period is a parameter so simulation can shorten it
`timescale 1ns/1ps
`default_nettype none
`include "hbs_defs.svh"
module hbs_tick_div #(
  parameter int unsigned TICK_CYCLES = `HBS_TICK_CYCLES
) (
  input  wire logic ref_clk_i,  // control clock
  input  wire logic rst_n_i,    // sync reset, active low
  hbs_tick_if.src   tk          // tick out, restart in
);
  logic [31:0] cnt_ff;
  wire         wrap = (cnt_ff == 32'(TICK_CYCLES - 1));
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || tk.clr || wrap) cnt_ff <= 32'h0000_0000;
    else                            cnt_ff <= cnt_ff + 32'h0000_0001;
  end
  assign tk.tick = wrap && !tk.clr;
endmodule : hbs_tick_div
`default_nettype wire

//--- logic/hbs_sequencer.sv
// Purpose: holding brake release and motor power sequencing with terminal routing
// Assumes: commands, alarm and speed come from logic on the same clock;
//          settings are static configuration inputs
// Notes:   terminal select is caught at each reset release (restart)
`timescale 1ns/1ps
`default_nettype none
`include "hbs_defs.svh"

// What this block does
// - the brake release output drops whenever an alarm, or a servo-off command with the motor stopped, is seen.
// - with the motor stopped, the release output drops in the cycle the servo-off is taken.
// - motor power stays on after servo-off for 0 to 50 ticks of 10 ms, default 0.
// - that delay is used only when the motor is stopped at servo-off.
// - an alarm removes motor power at once, ignoring the delay.
// - during overtravel the release output stays on.
// - terminal select 0 disables the output, 1 (default) drives the first terminal pair.
// - select values 2 and 3 drive the second and third terminal pairs.
// - each terminal is the OR of all signals allocated to it.
// - with the motor rotating, the brake applies on speed below level or wait timer expiry.
module hbs_sequencer
  import hbs_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `HBS_TICK_CYCLES
) (
  input  wire logic        ref_clk_i,                // 200 MHz control clock
  input  wire logic        rst_n_i,                  // sync reset, active low
  input  wire logic        servo_power_on_cmd_i,     // servo-on command pulse
  input  wire logic        servo_power_off_cmd_i,    // servo-off command pulse
  input  wire logic        alarm_i,                  // alarm detected level
  input  wire logic        overtravel_i,             // overtravel level
  input  wire logic        motor_stopped_i,          // motor at rest level
  input  wire logic [13:0] motor_speed_i,            // speed magnitude, 1 rpm
  input  wire logic [5:0]  brake_to_poweroff_delay_i,// ticks, 0 to 50
  input  wire logic [13:0] brake_speed_level_i,      // rpm threshold
  input  wire logic [6:0]  brake_wait_time_running_i,// ticks, 10 to 100
  input  wire logic [1:0]  output_terminal_select_i, // terminal for release output
  input  wire logic [2:0]  other_out_i,              // other signals per terminal
  output logic             motor_power_o,            // motor power enable
  output logic             brake_release_out_o,      // release level before routing
  output logic [2:0]       io_connector_o            // output terminal pairs 1..3
);
  hbs_state_t  state_ff, nxt_state;
  logic [6:0]  cnt_ff, nxt_cnt;
  logic        pwr_ff, nxt_pwr;
  logic        rel_ff, nxt_rel;
  logic [1:0]  sel_ff;
  logic        sel_taken_ff;
  logic [2:0]  term_ff;
  hbs_tick_if  tk ();

  hbs_tick_div #(.TICK_CYCLES(TICK_CYCLES)) u_div (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .tk        (tk)
  );

  // delay settings above the top of the range act as the top of the range; the wait time is not clamped
  function automatic logic [5:0] clamp_delay(input logic [5:0] d);
    clamp_delay = (d > `HBS_DELAY_MAX) ? `HBS_DELAY_MAX : d;
  endfunction : clamp_delay

  wire       off_req   = servo_power_off_cmd_i && (state_ff == HBS_ON);
  wire       slow      = motor_speed_i < brake_speed_level_i;
  wire [5:0] dly       = clamp_delay(brake_to_poweroff_delay_i);
  assign tk.clr = off_req || alarm_i;

  // stopped off drops release first, running off drops power first
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_pwr   = pwr_ff;
    nxt_rel   = rel_ff;
    case (state_ff)
      HBS_OFF: begin
        if (servo_power_on_cmd_i && !alarm_i) begin
          nxt_state = HBS_ON;
          nxt_pwr   = 1'b1;
          nxt_rel   = 1'b1;
        end
      end
      HBS_ON: begin
        if (alarm_i) begin
          nxt_state = HBS_OFF;
          nxt_pwr   = 1'b0;
          nxt_rel   = 1'b0;
        end else if (servo_power_off_cmd_i && motor_stopped_i) begin
          nxt_rel = 1'b0;
          nxt_cnt = {1'b0, dly};
          if (dly == 6'h00) begin
            nxt_state = HBS_OFF;
            nxt_pwr   = 1'b0;
          end else begin
            nxt_state = HBS_STOP_DELAY;
          end
        end else if (servo_power_off_cmd_i) begin
          nxt_state = HBS_RUN_WAIT;
          nxt_pwr   = 1'b0;
          nxt_cnt   = brake_wait_time_running_i;
        end
      end
      HBS_STOP_DELAY: begin
        if (alarm_i || (tk.tick && cnt_ff == 7'h01)) begin
          nxt_state = HBS_OFF;
          nxt_pwr   = 1'b0;
        end else if (tk.tick) begin
          nxt_cnt = cnt_ff - 7'h01;
        end
      end
      HBS_RUN_WAIT: begin
        if (alarm_i || slow || (tk.tick && cnt_ff <= 7'h01)) begin
          nxt_state = HBS_OFF;
          nxt_rel   = 1'b0;
        end else if (tk.tick) begin
          nxt_cnt = cnt_ff - 7'h01;
        end
      end
      default: nxt_state = HBS_OFF;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_ff <= HBS_OFF;
      cnt_ff   <= 7'h00;
      pwr_ff   <= 1'b0;
      rel_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      pwr_ff   <= nxt_pwr;
      rel_ff   <= nxt_rel;
    end
  end

  // terminal select caught once after reset release only
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      sel_taken_ff <= 1'b0;
      sel_ff       <= `HBS_SEL_RST;
    end else if (!sel_taken_ff) begin
      sel_taken_ff <= 1'b1;
      sel_ff       <= output_terminal_select_i;
    end
  end

  // overtravel alone never applies the brake; a running off keeps release until the brake point
  wire       rel_now   = rel_ff && !alarm_i && !(off_req && motor_stopped_i);
  wire [2:0] route     = (sel_ff == `HBS_SEL_OFF) ? 3'h0
                       : (3'h1 << (sel_ff - 2'h1));
  // terminals follow the release output one cycle later
  wire [2:0] nxt_term  = other_out_i | (route & {3{rel_now}});

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) term_ff <= 3'h0;
    else          term_ff <= nxt_term;
  end

  assign motor_power_o       = pwr_ff;
  assign brake_release_out_o = rel_now;
  assign io_connector_o      = term_ff;

  a_alarm_power: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    alarm_i |=> !motor_power_o)
    else $error("power not removed after alarm");
  a_alarm_brake: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    alarm_i |-> !brake_release_out_o)
    else $error("release output high during alarm");
  a_off_brake: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (off_req && motor_stopped_i) |-> !brake_release_out_o ##1 !brake_release_out_o)
    else $error("release output not dropped at servo-off");
  a_zero_delay: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (off_req && motor_stopped_i && !alarm_i && dly == 6'h00) |=> !motor_power_o)
    else $error("power held with zero delay");
  a_delay_holds: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (off_req && motor_stopped_i && !alarm_i && dly != 6'h00) |=> motor_power_o)
    else $error("power dropped before delay");
  a_delay_end: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (state_ff == HBS_STOP_DELAY && tk.tick && cnt_ff == 7'h01) |=> !motor_power_o)
    else $error("power held after delay end");
  a_run_slow: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (state_ff == HBS_RUN_WAIT && slow) |=> (state_ff == HBS_OFF) && !rel_ff)
    else $error("brake not applied below speed level");
  a_term_off: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (sel_taken_ff && sel_ff == `HBS_SEL_OFF) |=> io_connector_o == $past(other_out_i))
    else $error("terminal driven with output disabled");
  a_sel_stable: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    sel_taken_ff |=> $stable(sel_ff))
    else $error("terminal select changed without restart");
  a_ot_release: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (state_ff == HBS_ON && overtravel_i && !alarm_i && !servo_power_off_cmd_i)
      |-> brake_release_out_o)
    else $error("brake applied during overtravel");
  // running and stopped sequences
  a_run_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (off_req && !motor_stopped_i && !alarm_i) |-> brake_release_out_o ##1 !motor_power_o)
    else $error("running servo-off sequence wrong");
  a_run_rel: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (state_ff == HBS_RUN_WAIT && !alarm_i) |-> brake_release_out_o)
    else $error("release dropped early while rotating");
  a_wait_end: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (state_ff == HBS_RUN_WAIT && tk.tick && cnt_ff <= 7'h01) |=> !rel_ff)
    else $error("brake not applied at wait expiry");
  a_stop_rel: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (state_ff == HBS_STOP_DELAY) |-> !brake_release_out_o)
    else $error("release high during power-off delay");
  // scenario covers

  c_stop_delay: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state_ff == HBS_STOP_DELAY ##1 state_ff == HBS_OFF);
  c_run_wait: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state_ff == HBS_RUN_WAIT ##1 state_ff == HBS_OFF);
  c_alarm_on: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state_ff == HBS_ON && alarm_i);
  c_ovt_hold: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state_ff == HBS_ON && overtravel_i);
  c_zero_delay: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    off_req && motor_stopped_i && dly == 6'h00);
endmodule : hbs_sequencer
`default_nettype wire

//--- bench/hbs_host_model.sv
// Purpose: host controller model issuing servo on/off commands
// Assumes: requests come from the bench at the falling edge
// Notes:   motion is allowed only after the release has settled
`timescale 1ns/1ps
`default_nettype none
module hbs_host_model #(
  parameter int unsigned SETTLE_CYCLES = 100
) (
  input  wire logic ref_clk_i,       // control clock
  input  wire logic rst_n_i,         // sync reset, active low
  input  wire logic req_on_i,        // bench asks for servo-on
  input  wire logic req_off_i,       // bench asks for servo-off
  input  wire logic brake_release_i, // release level seen from drive
  output logic      on_cmd_o,        // servo-on command
  output logic      off_cmd_o,       // servo-off command
  output logic      motion_ok_o      // motion reference may be sent
);
  logic [15:0] wait_ff;
  assign on_cmd_o    = req_on_i;
  assign off_cmd_o   = req_off_i;
  assign motion_ok_o = brake_release_i && (wait_ff == 16'h0000);
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || !brake_release_i) wait_ff <= 16'(SETTLE_CYCLES);
    else if (wait_ff != 16'h0000) wait_ff <= wait_ff - 16'h0001;
  end
endmodule : hbs_host_model
`default_nettype wire

//--- bench/tb_top.sv
// Purpose: self-checking bench for the holding brake sequencer
// Assumes: tick shortened to TC cycles
// Notes:   inputs change at the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int TC = 10;
  logic        clk = 0, rst_n = 0, req_on = 0, req_off = 0;
  logic        alarm = 0, ovt = 0, stopped = 1;
  logic [13:0] speed = 14'h0000, level = 14'h0064;
  logic [5:0]  dly = 6'h00;
  logic [6:0]  wt = 7'h000a;
  logic [1:0]  sel = 2'h1;
  logic [2:0]  oth = 3'h0;
  wire         on_cmd, off_cmd, mok, pwr, rel;
  wire  [2:0]  term;
  int          bad_count = 0, compares = 0;
  always #2.5 clk = ~clk;
  hbs_host_model #(.SETTLE_CYCLES(5 * TC)) u_host (.ref_clk_i(clk), .rst_n_i(rst_n),
    .req_on_i(req_on), .req_off_i(req_off), .brake_release_i(rel),
    .on_cmd_o(on_cmd), .off_cmd_o(off_cmd), .motion_ok_o(mok));
  hbs_sequencer #(.TICK_CYCLES(TC)) u_dut (.ref_clk_i(clk), .rst_n_i(rst_n),
    .servo_power_on_cmd_i(on_cmd), .servo_power_off_cmd_i(off_cmd), .alarm_i(alarm),
    .overtravel_i(ovt), .motor_stopped_i(stopped), .motor_speed_i(speed),
    .brake_to_poweroff_delay_i(dly), .brake_speed_level_i(level),
    .brake_wait_time_running_i(wt), .output_terminal_select_i(sel), .other_out_i(oth),
    .motor_power_o(pwr), .brake_release_out_o(rel), .io_connector_o(term));
  task stop_test;
    $display("mismatches %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task chk_bit(input logic got, input logic exp, input string m);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk_bit
  task chk_term(input logic [2:0] got, input logic [2:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk_term
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task do_reset;
    rst_n = 0;
    cyc(20);
    rst_n = 1;
    cyc(2);
  endtask : do_reset
  task servo_on;
    req_on = 1;
    cyc(1);
    req_on = 0;
    chk_bit(pwr, 1'b1, "power not on");
    chk_bit(rel, 1'b1, "release not on");
  endtask : servo_on
  task servo_off;
    req_off = 1;
    #1;
  endtask : servo_off
  // stopped motor: release drops at once, power after the programmed ticks
  task t_stop(input logic [5:0] d, input int ticks);
    int n;
    dly = d;
    stopped = 1;
    servo_on();
    servo_off();
    chk_bit(rel, 1'b0, "release held at servo-off");
    cyc(1);
    req_off = 0;
    n = 1;
    while (pwr === 1'b1 && n < 1000) begin
      cyc(1);
      n++;
    end
    chk_bit(n >= ticks * TC - 2 && n <= ticks * TC + 3, 1'b1, "power-off delay");
  endtask : t_stop
  // rotating motor: power drops at once, release on speed level or wait timer
  task t_run(input logic [13:0] spd, input int lo, input int hi);
    int n;
    dly = 6'h05;
    wt = 7'h02;
    stopped = 0;
    speed = 14'h01f4;
    servo_on();
    servo_off();
    chk_bit(rel, 1'b1, "release dropped at running servo-off");
    cyc(1);
    req_off = 0;
    chk_bit(pwr, 1'b0, "running power kept");
    speed = spd;
    n = 0;
    while (rel === 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    chk_bit(n >= lo && n <= hi, 1'b1, "running brake timing");
    stopped = 1;
    speed = 14'h0000;
  endtask : t_run
  task t_alarm;
    dly = 6'h05;
    servo_on();
    alarm = 1;
    #1;
    chk_bit(rel, 1'b0, "release held on alarm");
    cyc(1);
    chk_bit(pwr, 1'b0, "power held on alarm");
    alarm = 0;
    cyc(2);
    servo_on();
    servo_off();
    cyc(1);
    req_off = 0;
    chk_bit(pwr, 1'b1, "power dropped before delay");
    cyc(3);
    alarm = 1;
    cyc(1);
    chk_bit(pwr, 1'b0, "alarm waited for delay");
    alarm = 0;
    cyc(2);
  endtask : t_alarm
  task t_ovt;
    dly = 6'h00;
    servo_on();
    chk_bit(mok, 1'b0, "motion allowed at release");
    ovt = 1;
    cyc(8);
    chk_bit(rel, 1'b1, "release dropped in overtravel");
    chk_bit(mok, 1'b0, "motion allowed too early");
    cyc(5 * TC - 8);
    chk_bit(mok, 1'b1, "motion not allowed after settle");
    ovt = 0;
    servo_off();
    cyc(1);
    req_off = 0;
    cyc(2);
  endtask : t_ovt
  task t_route(input logic [1:0] s, input logic [2:0] e);
    sel = s;
    oth = 3'h0;
    do_reset();
    servo_on();
    cyc(1);
    chk_term(term, e, "routing");
    oth = 3'h2;
    sel = s + 2'h1;
    cyc(2);
    chk_term(term, e | 3'h2, "or with other outputs");
  endtask : t_route
  initial begin
    #(5 * 20000);
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    stop_test();
  end
  initial begin
    do_reset();
    chk_bit(pwr, 1'b0, "power after reset");
    chk_bit(rel, 1'b0, "release after reset");
    chk_term(term, 3'h0, "terminals after reset");
    t_stop(6'h00, 0);
    t_stop(6'h02, 2);
    t_stop(6'h32, 50);
    t_stop(6'h3f, 50);
    t_alarm();
    t_run(14'h0032, 0, 3);
    t_run(14'h01f4, 2 * TC - 2, 2 * TC + 3);
    t_ovt();
    t_route(2'h0, 3'h0);
    t_route(2'h1, 3'h1);
    t_route(2'h2, 3'h2);
    t_route(2'h3, 3'h4);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
